// file: shared/cca_pkg.sv
// shared constants for the counter array register access block
package cca_pkg;

  localparam int          CCA_CHANNELS   = 3;
  localparam int          CCA_BYTE_W     = 8;
  localparam int          CCA_WORD_W     = 16;

  // byte lanes of a 16-bit value
  localparam int          CCA_LOW_LSB    = 0;
  localparam int          CCA_HIGH_LSB   = 8;

  // register offsets in the special-function space
  localparam logic [7:0]  CNT_LOW_OFS    = 8'hf9;
  localparam logic [7:0]  CNT_HIGH_OFS   = 8'hfa;
  localparam logic [7:0]  CAP0_LOW_OFS   = 8'hfb;
  localparam logic [7:0]  CAP0_HIGH_OFS  = 8'hfc;
  localparam logic [7:0]  CAP1_LOW_OFS   = 8'he9;
  localparam logic [7:0]  CAP1_HIGH_OFS  = 8'hea;
  localparam logic [7:0]  CAP2_LOW_OFS   = 8'heb;
  localparam logic [7:0]  CAP2_HIGH_OFS  = 8'hec;

  // reset values and the unmapped read value
  localparam logic [15:0] CNT_RESET      = 16'h0000;
  localparam logic [7:0]  SNAP_RESET     = 8'h00;
  localparam logic [15:0] CAP_RESET      = 16'h0000;
  localparam logic [15:0] RELOAD_RESET   = 16'h0000;
  localparam logic        ENABLE_RESET   = 1'b0;
  localparam logic [7:0]  RDATA_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

  // counter step when the tick input is high
  localparam logic [15:0] CNT_STEP       = 16'h0001;

  // side effects of byte writes on the comparator enable
  localparam logic        ENABLE_ON_LOW  = 1'b0;
  localparam logic        ENABLE_ON_HIGH = 1'b1;

  // offset of a channel's low or high byte register
  function automatic logic [7:0] capOffset(input int chan, input logic high);
    logic [7:0] ofs;
    ofs = CAP0_LOW_OFS;
    if (chan == 0) begin
      ofs = high ? CAP0_HIGH_OFS : CAP0_LOW_OFS;
    end else if (chan == 1) begin
      ofs = high ? CAP1_HIGH_OFS : CAP1_LOW_OFS;
    end else begin
      ofs = high ? CAP2_HIGH_OFS : CAP2_LOW_OFS;
    end
    return ofs;
  endfunction : capOffset

  // replace one byte lane of a 16-bit word
  function automatic logic [15:0] putByte(input logic [15:0] word, input logic high,
                                          input logic [7:0] data);
    logic [15:0] res;
    res = word;
    if (high) begin
      res[CCA_HIGH_LSB +: CCA_BYTE_W] = data;
    end else begin
      res[CCA_LOW_LSB +: CCA_BYTE_W] = data;
    end
    return res;
  endfunction : putByte

endpackage : cca_pkg

// file: hw/cca_channel.sv
// one capture/compare channel: compare value, reload value, enable and match
`timescale 1ns/100ps
`default_nettype none
module cca_channel
  import cca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        wrLow,
  input  wire logic        wrHigh,
  input  wire logic [7:0]  wrData,
  input  wire logic        autoReloadSelect,
  input  wire logic        enableLoad,
  input  wire logic        enableLoadValue,
  input  wire logic [15:0] counterValue,
  output logic      [15:0] compareValue,
  output logic      [15:0] reloadValue,
  output logic             comparatorEnable,
  output logic             compareMatch
);

  logic [15:0] compare_q;
  logic [15:0] compare_d;
  logic [15:0] reload_q;
  logic [15:0] reload_d;
  logic        enable_q;
  logic        enable_d;
  logic        match_q;
  logic        match_d;
  logic        anyWrite;
  logic        wrHighLane;

  assign anyWrite   = wrLow | wrHigh;
  assign wrHighLane = wrHigh;

  // the select bit steers byte writes to the reload value instead
  assign compare_d = (anyWrite && !autoReloadSelect) ?
                     putByte(compare_q, wrHighLane, wrData) : compare_q;
  assign reload_d  = (anyWrite && autoReloadSelect) ?
                     putByte(reload_q, wrHighLane, wrData) : reload_q;

  // byte writes win over a mode register load when both come in the same cycle
  assign enable_d  = wrLow      ? ENABLE_ON_LOW  :
                     wrHigh     ? ENABLE_ON_HIGH :
                     enableLoad ? enableLoadValue : enable_q;

  assign match_d   = enable_q && (counterValue == compare_q);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      compare_q <= CAP_RESET;
      reload_q  <= RELOAD_RESET;
      enable_q  <= ENABLE_RESET;
      match_q   <= 1'b0;
    end else begin
      compare_q <= compare_d;
      reload_q  <= reload_d;
      enable_q  <= enable_d;
      match_q   <= match_d;
    end
  end

  assign compareValue     = compare_q;
  assign reloadValue      = reload_q;
  assign comparatorEnable = enable_q;
  assign compareMatch     = match_q;

endmodule : cca_channel
`default_nettype wire

// file: hw/cca_regs.sv
// register access for the counter array: counter bytes, snapshot, channel bytes
`timescale 1ns/100ps
`default_nettype none
module cca_regs
  import cca_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic [7:0]                   sfrAddr,
  input  wire logic [7:0]                   sfrWrData,
  input  wire logic                         sfrWrEn,
  input  wire logic                         sfrRdEn,
  output logic      [7:0]                   sfrRdData,
  input  wire logic                         countTick,
  input  wire logic                         autoReloadSelect,
  input  wire logic [CCA_CHANNELS-1:0]      enableLoad,
  input  wire logic [CCA_CHANNELS-1:0]      enableLoadValue,
  output logic      [15:0]                  counterValue,
  output logic      [CCA_CHANNELS-1:0][15:0] compareValue,
  output logic      [CCA_CHANNELS-1:0][15:0] reloadValue,
  output logic      [CCA_CHANNELS-1:0]      comparatorEnable,
  output logic      [CCA_CHANNELS-1:0]      compareMatch
);

  logic [15:0]                   counter_q;
  logic [15:0]                   counter_d;
  logic [7:0]                    snapshot_q;
  logic [7:0]                    snapshot_d;
  logic [7:0]                    rdData_q;
  logic [7:0]                    rdData_d;

  logic                          hitCntLow;
  logic                          hitCntHigh;
  logic [CCA_CHANNELS-1:0]       hitCapLow;
  logic [CCA_CHANNELS-1:0]       hitCapHigh;
  logic [CCA_CHANNELS-1:0]       wrCapLow;
  logic [CCA_CHANNELS-1:0]       wrCapHigh;
  logic [CCA_CHANNELS-1:0][15:0] chanWord;
  logic [CCA_CHANNELS-1:0][7:0]  chanByte;
  logic [7:0]                    chanRdByte;
  logic                          anyCapHit;
  logic                          lowRead;

  // address decode
  assign hitCntLow  = (sfrAddr == CNT_LOW_OFS);
  assign hitCntHigh = (sfrAddr == CNT_HIGH_OFS);
  assign lowRead    = sfrRdEn && hitCntLow;

  for (genvar i = 0; i < CCA_CHANNELS; i++) begin : g_dec
    assign hitCapLow[i]  = (sfrAddr == capOffset(i, 1'b0));
    assign hitCapHigh[i] = (sfrAddr == capOffset(i, 1'b1));
    assign wrCapLow[i]   = sfrWrEn && hitCapLow[i];
    assign wrCapHigh[i]  = sfrWrEn && hitCapHigh[i];
    // reads follow the same select as writes
    assign chanWord[i]   = autoReloadSelect ? reloadValue[i] : compareValue[i];
    assign chanByte[i]   = hitCapHigh[i] ? chanWord[i][CCA_HIGH_LSB +: CCA_BYTE_W] :
                           hitCapLow[i]  ? chanWord[i][CCA_LOW_LSB +: CCA_BYTE_W]  :
                           UNMAPPED_READ;
  end : g_dec

  assign anyCapHit  = |(hitCapLow | hitCapHigh);
  // at most one channel decodes, so or-ing the lanes is a clean select
  assign chanRdByte = chanByte[0] | chanByte[1] | chanByte[2];

  // counter: a bus write wins over the tick in the same cycle
  assign counter_d = (sfrWrEn && hitCntLow)  ? putByte(counter_q, 1'b0, sfrWrData) :
                     (sfrWrEn && hitCntHigh) ? putByte(counter_q, 1'b1, sfrWrData) :
                     countTick               ? counter_q + CNT_STEP :
                     counter_q;

  // snapshot keeps the two bytes of one 16-bit read coherent
  assign snapshot_d = lowRead ? counter_q[CCA_HIGH_LSB +: CCA_BYTE_W] : snapshot_q;

  assign rdData_d = !sfrRdEn  ? rdData_q :
                    hitCntLow  ? counter_q[CCA_LOW_LSB +: CCA_BYTE_W] :
                    hitCntHigh ? snapshot_q :
                    anyCapHit  ? chanRdByte :
                    UNMAPPED_READ;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      counter_q  <= CNT_RESET;
      snapshot_q <= SNAP_RESET;
      rdData_q   <= RDATA_RESET;
    end else begin
      counter_q  <= counter_d;
      snapshot_q <= snapshot_d;
      rdData_q   <= rdData_d;
    end
  end

  assign sfrRdData    = rdData_q;
  assign counterValue = counter_q;

  // software writes low then high; the low write disarms the match meanwhile
  for (genvar i = 0; i < CCA_CHANNELS; i++) begin : g_chan
    cca_channel u_chan (
      .mclk             (mclk),
      .reset_n          (reset_n),
      .wrLow            (wrCapLow[i]),
      .wrHigh           (wrCapHigh[i]),
      .wrData           (sfrWrData),
      .autoReloadSelect (autoReloadSelect),
      .enableLoad       (enableLoad[i]),
      .enableLoadValue  (enableLoadValue[i]),
      .counterValue     (counter_q),
      .compareValue     (compareValue[i]),
      .reloadValue      (reloadValue[i]),
      .comparatorEnable (comparatorEnable[i]),
      .compareMatch     (compareMatch[i])
    );
  end : g_chan

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_counter_low_write: assert property (
    sfrWrEn && hitCntLow |=> counter_q[7:0] == $past(sfrWrData)
  ) else $error("counter low byte write lost");

  a_counter_high_write: assert property (
    sfrWrEn && hitCntHigh |=> counter_q[15:8] == $past(sfrWrData)
  ) else $error("counter high byte write lost");

  a_counter_low_read: assert property (
    sfrRdEn && hitCntLow |=> sfrRdData == $past(counter_q[7:0])
  ) else $error("counter low byte read wrong");

  a_snapshot_load: assert property (
    lowRead ##1 (sfrRdEn && hitCntHigh) |=> sfrRdData == $past(counter_q[15:8], 2)
  ) else $error("high byte read does not match low read snapshot");

  a_snapshot_hold: assert property (
    !lowRead |=> $stable(snapshot_q)
  ) else $error("snapshot changed without a low byte read");

  for (genvar i = 0; i < CCA_CHANNELS; i++) begin : g_chk
    a_low_clears_enable: assert property (
      wrCapLow[i] |=> !comparatorEnable[i]
    ) else $error("low byte write did not clear comparator enable");

    a_high_sets_enable: assert property (
      wrCapHigh[i] |=> comparatorEnable[i]
    ) else $error("high byte write did not set comparator enable");

    a_compare_write: assert property (
      wrCapHigh[i] && !autoReloadSelect |=>
        compareValue[i][15:8] == $past(sfrWrData) && $stable(reloadValue[i])
    ) else $error("compare high byte write misrouted");

    a_reload_steer: assert property (
      (wrCapLow[i] || wrCapHigh[i]) && autoReloadSelect |=>
        $stable(compareValue[i]) && ($past(sfrWrData) ==
        ($past(wrCapHigh[i]) ? reloadValue[i][15:8] : reloadValue[i][7:0]))
    ) else $error("reload select did not redirect the byte write");

    a_match_gated: assert property (
      compareMatch[i] |-> $past(comparatorEnable[i]) &&
                          $past(counter_q) == $past(compareValue[i])
    ) else $error("compare match without enable or equality");
  end : g_chk

endmodule : cca_regs
`default_nettype wire

// file: verif/tb_top.sv
// self-checking testbench for the counter array register access block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cca_pkg::*;
;
  logic                          mclk, reset_n, sfrWrEn, sfrRdEn;
  logic                          countTick, autoReloadSelect;
  logic [7:0]                    sfrAddr, sfrWrData, sfrRdData, rdVal;
  logic [2:0]                    enableLoad, enableLoadValue, comparatorEnable, compareMatch;
  logic [15:0]                   counterValue;
  logic [CCA_CHANNELS-1:0][15:0] compareValue, reloadValue;
  logic [7:0]                    loOfs [3] = '{CAP0_LOW_OFS, CAP1_LOW_OFS, CAP2_LOW_OFS};
  logic [7:0]                    hiOfs [3] = '{CAP0_HIGH_OFS, CAP1_HIGH_OFS, CAP2_HIGH_OFS};
  int                            err_total, checks_done;

  cca_regs uut (.mclk(mclk), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .countTick(countTick),
    .autoReloadSelect(autoReloadSelect), .enableLoad(enableLoad),
    .enableLoadValue(enableLoadValue), .counterValue(counterValue),
    .compareValue(compareValue), .reloadValue(reloadValue),
    .comparatorEnable(comparatorEnable), .compareMatch(compareMatch));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // strobes drop one cycle later, so back-to-back calls never touch a signal twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    sfrWrEn = 1'b1; sfrAddr = a; sfrWrData = d;
    @(posedge mclk) #1;
    sfrWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk) #1;
    sfrRdEn = 1'b1; sfrAddr = a;
    @(posedge mclk) #1;
    sfrRdEn = 1'b0;
    rdVal = sfrRdData;
  endtask : rd

  task automatic test_reset;
    logic [7:0] ofs [8] = '{CNT_LOW_OFS, CNT_HIGH_OFS, CAP0_LOW_OFS, CAP0_HIGH_OFS,
                            CAP1_LOW_OFS, CAP1_HIGH_OFS, CAP2_LOW_OFS, CAP2_HIGH_OFS};
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i]);
      chk({8'h00, rdVal}, 16'h0000);
    end
    wr(8'h80, 8'h5a);
    rd(8'h80);
    chk({8'h00, rdVal}, 16'h0000);
    $display("test reset done");
  endtask : test_reset

  task automatic test_counter;
    wr(CNT_LOW_OFS, 8'hff);
    wr(CNT_HIGH_OFS, 8'h12);
    chk(counterValue, 16'h12ff);
    rd(CNT_LOW_OFS);
    chk({8'h00, rdVal}, 16'h00ff);
    @(posedge mclk) #1;
    countTick = 1'b1;
    @(posedge mclk) #1;
    countTick = 1'b0;
    chk(counterValue, 16'h1300);
    // live high byte is now 0x13, the snapshot still holds 0x12
    rd(CNT_HIGH_OFS);
    chk({8'h00, rdVal}, 16'h0012);
    rd(CNT_LOW_OFS);
    chk({8'h00, rdVal}, 16'h0000);
    rd(CNT_HIGH_OFS);
    chk({8'h00, rdVal}, 16'h0013);
    // live high byte moves to 0x21; a back-to-back low/high read must see it
    wr(CNT_HIGH_OFS, 8'h21);
    @(posedge mclk) #1;
    sfrRdEn = 1'b1; sfrAddr = CNT_LOW_OFS;
    @(posedge mclk) #1;
    sfrAddr = CNT_HIGH_OFS;
    @(posedge mclk) #1;
    sfrRdEn = 1'b0;
    rdVal = sfrRdData;
    chk({8'h00, rdVal}, 16'h0021);
    $display("test counter done");
  endtask : test_counter

  task automatic test_channels;
    for (int c = 0; c < 3; c++) begin
      @(posedge mclk) #1;
      enableLoad[c] = 1'b1; enableLoadValue[c] = 1'b1;
      @(posedge mclk) #1;
      enableLoad = 3'h0; enableLoadValue = 3'h0;
      chk({15'h0000, comparatorEnable[c]}, 16'h0001);
      // low byte first, then high byte
      wr(loOfs[c], 8'h5a + 8'(c));
      chk({15'h0000, comparatorEnable[c]}, 16'h0000);
      wr(hiOfs[c], 8'hc0 + 8'(c));
      chk({15'h0000, comparatorEnable[c]}, 16'h0001);
      chk(compareValue[c], {8'hc0 + 8'(c), 8'h5a + 8'(c)});
      rd(loOfs[c]);
      chk({8'h00, rdVal}, {8'h00, 8'h5a + 8'(c)});
      rd(hiOfs[c]);
      chk({8'h00, rdVal}, {8'h00, 8'hc0 + 8'(c)});
    end
    $display("test channels done");
  endtask : test_channels

  task automatic test_reload;
    @(posedge mclk) #1;
    autoReloadSelect = 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(loOfs[c], 8'h30 + 8'(c));
      chk({15'h0000, comparatorEnable[c]}, 16'h0000);
      wr(hiOfs[c], 8'h70 + 8'(c));
      chk({15'h0000, comparatorEnable[c]}, 16'h0001);
      chk(reloadValue[c], {8'h70 + 8'(c), 8'h30 + 8'(c)});
      chk(compareValue[c], {8'hc0 + 8'(c), 8'h5a + 8'(c)});
      rd(loOfs[c]);
      chk({8'h00, rdVal}, {8'h00, 8'h30 + 8'(c)});
    end
    @(posedge mclk) #1;
    autoReloadSelect = 1'b0;
    $display("test reload done");
  endtask : test_reload

  task automatic test_match;
    wr(CNT_LOW_OFS, 8'h5a);
    wr(CNT_HIGH_OFS, 8'hc0);
    repeat (2) @(posedge mclk);
    #1;
    chk({15'h0000, compareMatch[0]}, 16'h0001);
    wr(CAP0_LOW_OFS, 8'h5a);
    repeat (2) @(posedge mclk);
    #1;
    chk({15'h0000, compareMatch[0]}, 16'h0000);
    $display("test match done");
  endtask : test_match

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // the tests need well under a thousand cycles
  initial begin
    #(8 * 5000);
    err_total++;
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0; sfrWrEn = 1'b0; sfrRdEn = 1'b0; sfrAddr = 8'h00; sfrWrData = 8'h00;
    countTick = 1'b0; autoReloadSelect = 1'b0; enableLoad = 3'h0; enableLoadValue = 3'h0;
    repeat (6) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    test_reset();
    test_counter();
    test_channels();
    test_reload();
    test_match();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
